// [rtl/ring_status_defs.svh]
// offsets, field positions, reset values and timing counts of the status bank
// assumes byte addressing on a 32-bit bus, one register per aligned word
`ifndef RING_STATUS_DEFS_SVH
`define RING_STATUS_DEFS_SVH

`define RSS_OFF_TIMEOUT 12'h50c
`define RSS_OFF_INIT_DONE 12'h510
`define RSS_OFF_IRQ_MASK 12'h514
`define RSS_OFF_STATE 12'h544
`define RSS_OFF_OVERFLOW 12'h548
`define RSS_OFF_ERR_FLAGS 12'h54c
`define RSS_OFF_BLK_ERR_LO 12'h550
`define RSS_OFF_BLK_ERR_HI 12'h554
`define RSS_OFF_NODE_POS 12'h558
`define RSS_OFF_FIRST_BLK 12'h55c
`define RSS_OFF_NODE_TOT 12'h560
`define RSS_OFF_BLK_TOT 12'h564

`define RSS_PH_INIT 4'h8
`define RSS_PH_CFG_A 4'h4
`define RSS_PH_CFG_B 4'h2
`define RSS_PH_RUN 4'h1

`define RSS_ERR_SHORT 12
`define RSS_ERR_RT_MARK 11
`define RSS_ERR_B_MARK 9
`define RSS_ERR_A_MARK 8
`define RSS_ERR_MII 7
`define RSS_ERR_BLK_OR 6
`define RSS_ERR_RT_FCS 5
`define RSS_ERR_B_FCS 3
`define RSS_ERR_A_FCS 2
`define RSS_ERR_TIMEOUT 1
`define RSS_ERR_FID 0

`define RSS_RING_MAX 8'h20
`define RSS_TIMEOUT_RST 8'hff
`define RSS_TMO_UNIT_NS 81920
`define RSS_CLK_PERIOD_NS 8

`endif

// [rtl/ring_status_pkg.sv]
// types shared by the status bank
// assumes nothing of its surroundings
package ring_status_pkg;
   typedef enum logic [1:0] {FT_INIT_A, FT_INIT_B, FT_INIT_C, FT_REALTIME} frame_type_t;
   typedef enum logic [1:0] {PH_INIT, PH_CFG_A, PH_CFG_B, PH_RUN} phase_t;
endpackage : ring_status_pkg

// [rtl/ring_slave_status_regs.sv]
// status and error register bank of a ring slave node, avalon-mm slave
// assumes frame events come from receive logic on i_sys_clk; mii pins are async
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
`include "ring_status_defs.svh"

// Summary of operation
// RULE_01: phase reported one-hot in state bits 3:0
// RULE_02: last received frame id in bits 15:8
// RULE_03: config A, block total above 32 flags
// RULE_04: config A, node total above 32 flags
// RULE_05: error flags latch, clear on read
// RULE_06: short frame sets flag 12
// RULE_07: real-time error marking sets flag 11
// RULE_08: init-B/A error marking set flags 9/8
// RULE_09: flags 10 and 4 read zero
// RULE_10: mii rx error with valid sets 7
// RULE_11: flag 6 is live OR of blocks
// RULE_12: real-time frame check failure sets 5
// RULE_13: init-B/A frame check failure set 3/2
// RULE_14: running phase frame timeout sets flag 1
// RULE_15: frame id error sets flag 0
// RULE_16: short or id error suppress irq, sync
// RULE_17: timeout suppresses sync, irq when masked
// RULE_18: handlers see previous frame's errors
// RULE_19: per-block check errors, clear on read
// RULE_20: software judges data by block errors
// RULE_21: config A captures own ring position
// RULE_22: config A captures own first block
// RULE_23: config B captures node and block totals
// RULE_24: timeout is 81.92 us times setting
// RULE_25: init complete moves initial to config A
// RULE_26: irq on timeout unless mask set
// RULE_27: unused bits zero, status writes ignored
module ring_slave_status_regs #(
   parameter int TMO_UNIT_CYCLES = `RSS_TMO_UNIT_NS / `RSS_CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // avalon-mm slave
   input wire logic [11:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // frame events from receive logic
   input wire logic i_frame_done,
   input wire ring_status_pkg::frame_type_t i_frame_type,
   input wire logic [7:0] i_frame_id,
   input wire logic i_short_frame,
   input wire logic i_err_mark,
   input wire logic i_fcs_fail,
   input wire logic i_frame_id_err,
   input wire logic [31:0] i_blk_crc_err,
   input wire logic [7:0] i_node_count_in,
   input wire logic [7:0] i_block_count_in,
   input wire logic [10:0] i_node_sum,
   input wire logic [10:0] i_block_sum,
   // mii pins
   input wire logic i_mii_rx_er,
   input wire logic i_mii_rx_dv,
   // node outputs
   output logic o_receive_irq_n,
   output logic o_sync_pulse_n
);
   import ring_status_pkg::*;

   typedef struct packed {
      phase_t phase;
      logic [7:0] frame_id;
      logic ovf_blk;
      logic ovf_node;
      logic [12:0] flags;
      logic [12:0] pend;
      logic [31:0] blk_err;
      logic [7:0] node_pos;
      logic [7:0] first_blk;
      logic [10:0] node_tot;
      logic [10:0] blk_tot;
      logic [7:0] tmo_set;
      logic init_done;
      logic tmo_mask;
      logic [15:0] unit_cnt;
      logic [7:0] tmo_cnt;
      logic irq_n;
      logic sync_n;
      logic ack;
      logic [31:0] rdata;
      logic [1:0] er_sync;
      logic [1:0] dv_sync;
   } state_t;

   state_t q_ff;
   state_t nxt_q;
   logic req;
   logic done_rd;
   logic done_wr;
   logic fe;
   logic bad;
   logic good;
   logic wrap;
   logic tmo_fire;
   logic [12:0] errs;

   function automatic logic [3:0] phase_code(input phase_t p);
      case (p)
         PH_INIT: phase_code = `RSS_PH_INIT;
         PH_CFG_A: phase_code = `RSS_PH_CFG_A;
         PH_CFG_B: phase_code = `RSS_PH_CFG_B;
         PH_RUN: phase_code = `RSS_PH_RUN;
         default: phase_code = 4'h0;
      endcase
   endfunction : phase_code

   function automatic logic [12:0] frame_errs(input frame_type_t t, input logic sh,
      input logic mk, input logic fcs, input logic fid);
      logic [12:0] v;
      v = '0;
      v[`RSS_ERR_SHORT] = sh; // [RULE_06]
      v[`RSS_ERR_FID] = fid; // [RULE_15]
      case (t)
         FT_INIT_A:
         begin
            v[`RSS_ERR_A_MARK] = mk; // [RULE_08]
            v[`RSS_ERR_A_FCS] = fcs; // [RULE_13]
         end
         FT_INIT_B:
         begin
            v[`RSS_ERR_B_MARK] = mk; // [RULE_08]
            v[`RSS_ERR_B_FCS] = fcs; // [RULE_13]
         end
         FT_REALTIME:
         begin
            v[`RSS_ERR_RT_MARK] = mk; // [RULE_07]
            v[`RSS_ERR_RT_FCS] = fcs; // [RULE_12]
         end
         default: v = v; // init-c frame type is unused [RULE_09]
      endcase
      frame_errs = v;
   endfunction : frame_errs

   function automatic logic [31:0] rd_word(input state_t s, input logic [11:0] a);
      logic [15:0] f;
      f = {3'h0, s.flags[12:11], 1'b0, s.flags[9:7], |s.blk_err, s.flags[5], 1'b0,
         s.flags[3:0]}; // [RULE_09] [RULE_11]
      case (a)
         `RSS_OFF_TIMEOUT: rd_word = {24'h0, s.tmo_set};
         `RSS_OFF_INIT_DONE: rd_word = {31'h0, s.init_done};
         `RSS_OFF_IRQ_MASK: rd_word = {31'h0, s.tmo_mask};
         `RSS_OFF_STATE: rd_word = {16'h0, s.frame_id, 4'h0, phase_code(s.phase)}; // [RULE_01] [RULE_02]
         `RSS_OFF_OVERFLOW: rd_word = {30'h0, s.ovf_blk, s.ovf_node};
         `RSS_OFF_ERR_FLAGS: rd_word = {16'h0, f};
         `RSS_OFF_BLK_ERR_LO: rd_word = {16'h0, s.blk_err[15:0]};
         `RSS_OFF_BLK_ERR_HI: rd_word = {16'h0, s.blk_err[31:16]};
         `RSS_OFF_NODE_POS: rd_word = {24'h0, s.node_pos};
         `RSS_OFF_FIRST_BLK: rd_word = {24'h0, s.first_blk};
         `RSS_OFF_NODE_TOT: rd_word = {21'h0, s.node_tot};
         `RSS_OFF_BLK_TOT: rd_word = {21'h0, s.blk_tot};
         default: rd_word = 32'h0; // unused bits and unmapped addresses read zero [RULE_27]
      endcase
   endfunction : rd_word

   assign req = i_avs_read | i_avs_write;
   assign done_rd = q_ff.ack & i_avs_read;
   assign done_wr = q_ff.ack & i_avs_write;
   assign fe = i_frame_done & (q_ff.phase != PH_INIT); // frames ignored before init
   assign errs = frame_errs(i_frame_type, i_short_frame, i_err_mark, i_fcs_fail, i_frame_id_err);
   assign bad = i_short_frame | i_frame_id_err;
   assign good = fe & ~(|errs);
   assign wrap = q_ff.unit_cnt == 16'(TMO_UNIT_CYCLES - 1);
   // a setting lowered below the elapsed time fires at the next unit, no count wrap
   assign tmo_fire = (q_ff.phase == PH_RUN) & (q_ff.tmo_set != 8'h00) & ~fe & wrap
      & (q_ff.tmo_cnt >= q_ff.tmo_set - 8'h01); // [RULE_14] [RULE_24]
   assign o_avs_waitrequest = req & ~q_ff.ack;
   assign o_avs_readdata = q_ff.rdata;
   assign o_receive_irq_n = q_ff.irq_n;
   assign o_sync_pulse_n = q_ff.sync_n;

   always_comb
   begin
      nxt_q = q_ff;
      // bus: one wait cycle, data captured on the first
      nxt_q.ack = req & ~q_ff.ack;
      if (req & ~q_ff.ack)
      begin
         nxt_q.rdata = rd_word(q_ff, i_avs_address);
      end
      if (done_wr & i_avs_byteenable[0])
      begin
         case (i_avs_address)
            `RSS_OFF_TIMEOUT: nxt_q.tmo_set = i_avs_writedata[7:0];
            `RSS_OFF_INIT_DONE: nxt_q.init_done = i_avs_writedata[0] | q_ff.init_done;
            `RSS_OFF_IRQ_MASK: nxt_q.tmo_mask = i_avs_writedata[0];
            default: nxt_q.tmo_mask = q_ff.tmo_mask; // status registers ignore writes [RULE_27]
         endcase
      end
      // clears on read first, so a same-cycle set wins
      // only bits already in the read word clear; a set after capture survives
      if (done_rd && i_avs_address == `RSS_OFF_ERR_FLAGS)
      begin
         nxt_q.flags = q_ff.flags & ~q_ff.rdata[12:0]; // [RULE_05]
      end
      if (done_rd && i_avs_address == `RSS_OFF_BLK_ERR_LO)
      begin
         nxt_q.blk_err[15:0] = q_ff.blk_err[15:0] & ~q_ff.rdata[15:0]; // [RULE_19]
      end
      if (done_rd && i_avs_address == `RSS_OFF_BLK_ERR_HI)
      begin
         nxt_q.blk_err[31:16] = q_ff.blk_err[31:16] & ~q_ff.rdata[15:0]; // [RULE_19]
      end
      // mii error sampling through two flops
      nxt_q.er_sync = {q_ff.er_sync[0], i_mii_rx_er};
      nxt_q.dv_sync = {q_ff.dv_sync[0], i_mii_rx_dv};
      if (q_ff.er_sync[1] & q_ff.dv_sync[1])
      begin
         nxt_q.flags[`RSS_ERR_MII] = 1'b1; // [RULE_10]
      end
      // a frame's error flags become visible only at the next frame; block errors at once
      if (fe)
      begin
         nxt_q.flags = nxt_q.flags | q_ff.pend; // [RULE_05] [RULE_18]
         nxt_q.pend = errs;
         nxt_q.frame_id = i_frame_id; // [RULE_02]
         if (q_ff.phase == PH_RUN)
         begin
            nxt_q.blk_err = nxt_q.blk_err | i_blk_crc_err; // [RULE_19]
         end
      end
      // phase sequence
      case (q_ff.phase)
         PH_INIT:
         begin
            if (q_ff.init_done)
            begin
               nxt_q.phase = PH_CFG_A; // [RULE_25]
            end
         end
         PH_CFG_A:
         begin
            if (good && i_frame_type == FT_INIT_A)
            begin
               nxt_q.ovf_blk = q_ff.ovf_blk | (i_block_count_in > `RSS_RING_MAX); // [RULE_03]
               nxt_q.ovf_node = q_ff.ovf_node | (i_node_count_in > `RSS_RING_MAX); // [RULE_04]
               nxt_q.node_pos = i_node_count_in; // [RULE_21]
               nxt_q.first_blk = i_block_count_in; // [RULE_22]
               nxt_q.phase = PH_CFG_B;
            end
         end
         PH_CFG_B:
         begin
            if (good && i_frame_type == FT_INIT_B)
            begin
               nxt_q.node_tot = i_node_sum; // [RULE_23]
               nxt_q.blk_tot = i_block_sum; // [RULE_23]
               nxt_q.phase = PH_RUN;
            end
         end
         PH_RUN: nxt_q.phase = PH_RUN;
         default: nxt_q.phase = PH_INIT;
      endcase
      // timeout timer, restarted by every frame
      if (fe || q_ff.phase != PH_RUN || q_ff.tmo_set == 8'h00 || tmo_fire)
      begin
         nxt_q.unit_cnt = 16'h0;
         nxt_q.tmo_cnt = 8'h0;
      end
      else if (wrap)
      begin
         nxt_q.unit_cnt = 16'h0;
         nxt_q.tmo_cnt = q_ff.tmo_cnt + 8'h01;
      end
      else
      begin
         nxt_q.unit_cnt = q_ff.unit_cnt + 16'h1;
      end
      if (tmo_fire)
      begin
         nxt_q.flags[`RSS_ERR_TIMEOUT] = 1'b1; // [RULE_14]
      end
      // one-cycle low pulses
      nxt_q.sync_n = ~(fe & ~bad); // [RULE_16] [RULE_17]
      nxt_q.irq_n = ~((fe & ~bad) | (tmo_fire & ~q_ff.tmo_mask)); // [RULE_16] [RULE_26]
      nxt_q.flags[10] = 1'b0; // [RULE_09]
      nxt_q.flags[4] = 1'b0; // [RULE_09]
      nxt_q.flags[6] = 1'b0;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         q_ff <= '0;
         q_ff.tmo_set <= `RSS_TIMEOUT_RST;
         q_ff.irq_n <= 1'b1;
         q_ff.sync_n <= 1'b1;
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

   chk_phase_onehot: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_01]
      (done_rd && i_avs_address == `RSS_OFF_STATE) |-> $onehot(o_avs_readdata[3:0]))
      else $error("phase code not one-hot");
   chk_bus_one_wait: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (req && !q_ff.ack) |=> (q_ff.ack && !o_avs_waitrequest) || !req)
      else $error("answer not after one wait cycle");
   chk_bad_frame_quiet: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_16]
      (fe && bad) |=> (o_receive_irq_n && o_sync_pulse_n)) else $error("pulse on bad frame");
   chk_good_frame_pulse: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_16]
      (fe && !bad) |=> (!o_receive_irq_n && !o_sync_pulse_n) ##1 o_sync_pulse_n)
      else $error("missing one-cycle frame pulses");
   chk_timeout_mask: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_17]
      tmo_fire |=> o_sync_pulse_n && (o_receive_irq_n == $past(q_ff.tmo_mask)))
      else $error("timeout pulse wrong");
   chk_flags_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_05]
      (done_rd && i_avs_address == `RSS_OFF_ERR_FLAGS && !fe && !tmo_fire
      && !(q_ff.er_sync[1] && q_ff.dv_sync[1]))
      |=> (q_ff.flags & $past(o_avs_readdata[12:0])) == 13'h0)
      else $error("flags not cleared by read");
   chk_flags_reserved: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_09]
      (done_rd && $past(i_avs_address) == `RSS_OFF_ERR_FLAGS)
      |-> (o_avs_readdata[10] == 1'b0 && o_avs_readdata[4] == 1'b0
      && o_avs_readdata[31:13] == 19'h0)) else $error("reserved flag bits set");
   chk_prev_frame_errs: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_18]
      (fe && i_short_frame && !q_ff.pend[12]) |=> q_ff.pend[12] && !$rose(q_ff.flags[12]))
      else $error("frame errors shown too early");
   chk_init_to_cfga: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_25]
      (q_ff.phase == PH_INIT && q_ff.init_done) |=> q_ff.phase == PH_CFG_A)
      else $error("init complete ignored");
   chk_node_overflow: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_04]
      (q_ff.phase == PH_CFG_A && good && i_frame_type == FT_INIT_A
      && i_node_count_in > `RSS_RING_MAX) |=> q_ff.ovf_node) else $error("node overflow missed");
   chk_blk_overflow: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_03]
      (q_ff.phase == PH_CFG_A && good && i_frame_type == FT_INIT_A
      && i_block_count_in > `RSS_RING_MAX) |=> q_ff.ovf_blk)
      else $error("block overflow missed");
   chk_mii_error: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_10]
      (q_ff.er_sync[1] && q_ff.dv_sync[1]) |=> q_ff.flags[`RSS_ERR_MII])
      else $error("mii error not flagged");
   chk_blk_run_only: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_19]
      (q_ff.phase != PH_RUN && q_ff.blk_err == 32'h0) |=> q_ff.blk_err == 32'h0)
      else $error("block error outside running phase");

endmodule : ring_slave_status_regs

// [verif/ring_frame_source.sv]
// receive-logic model feeding frame events into the status bank
// assumes the bench calls send_frame from one thread, frames 2+ cycles apart
`timescale 1ns/100ps
module ring_frame_source (
   // clock
   input wire logic i_sys_clk,
   // frame event and fields
   output logic o_done,
   output ring_status_pkg::frame_type_t o_type,
   output logic [7:0] o_id,
   output logic [3:0] o_errs,
   output logic [31:0] o_blk,
   output logic [7:0] o_nc,
   output logic [7:0] o_bc,
   output logic [10:0] o_ns,
   output logic [10:0] o_bs
);
   import ring_status_pkg::*;

   initial
   begin
      o_done = 1'b0;
      o_type = FT_REALTIME;
      {o_id, o_errs, o_blk, o_nc, o_bc, o_ns, o_bs} = '0;
   end

   // one-cycle event; fields scrambled once the event is gone
   task automatic send_frame(input frame_type_t t, input logic [7:0] id, input logic [3:0] e,
      input logic [31:0] b, input logic [7:0] nc, input logic [7:0] bc,
      input logic [10:0] ns, input logic [10:0] bs);
      @(posedge i_sys_clk);
      o_done <= 1'b1;
      o_type <= t;
      {o_id, o_errs, o_blk, o_nc, o_bc, o_ns, o_bs} <= {id, e, b, nc, bc, ns, bs};
      @(posedge i_sys_clk);
      o_done <= 1'b0;
      o_type <= frame_type_t'(~t);
      {o_id, o_errs, o_blk, o_nc, o_bc, o_ns, o_bs} <= ~{id, e, b, nc, bc, ns, bs};
   endtask : send_frame
endmodule : ring_frame_source

// [verif/ring_slave_status_regs_tb_top.sv]
// self-checking bench of the ring slave status bank
// assumes the frame model above and avalon-mm timing of one wait state
`timescale 1ns/100ps
`include "ring_status_defs.svh"
module ring_slave_status_regs_tb_top;
   import ring_status_pkg::*;
   typedef struct packed {frame_type_t t; logic [3:0] e; logic [15:0] m;} ecase_t;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, rx_er = 1'b0, rx_dv = 1'b0;
   logic [11:0] addr = '0;
   logic [31:0] wdata = '0, rdata, q;
   logic wait_req, irq_n, sync_n, f_done;
   frame_type_t f_type;
   logic [7:0] f_id, f_nc, f_bc;
   logic [3:0] f_errs;
   logic [31:0] f_blk;
   logic [10:0] f_ns, f_bs;
   int err_total = 0, samples_checked = 0;
   logic [11:0] ra [10] = '{`RSS_OFF_STATE, `RSS_OFF_OVERFLOW, `RSS_OFF_ERR_FLAGS,
      `RSS_OFF_BLK_ERR_LO, `RSS_OFF_BLK_ERR_HI, `RSS_OFF_NODE_POS, `RSS_OFF_FIRST_BLK,
      `RSS_OFF_NODE_TOT, `RSS_OFF_BLK_TOT, 12'h600};
   ecase_t tbl [9] = '{{FT_REALTIME, 4'h8, 16'h1000}, {FT_REALTIME, 4'h4, 16'h0800},
      {FT_REALTIME, 4'h2, 16'h0020}, {FT_REALTIME, 4'h1, 16'h0001},
      {FT_INIT_B, 4'h4, 16'h0200}, {FT_INIT_A, 4'h4, 16'h0100},
      {FT_INIT_B, 4'h2, 16'h0008}, {FT_INIT_A, 4'h2, 16'h0004}, {FT_INIT_C, 4'h6, 16'h0000}};

   initial
   begin
      forever #4 clk = ~clk;
   end

   ring_frame_source src (.i_sys_clk(clk), .o_done(f_done), .o_type(f_type), .o_id(f_id),
      .o_errs(f_errs), .o_blk(f_blk), .o_nc(f_nc), .o_bc(f_bc), .o_ns(f_ns), .o_bs(f_bs));

   ring_slave_status_regs #(.TMO_UNIT_CYCLES(4)) dut (.i_sys_clk(clk), .i_reset(rst),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
      .i_frame_done(f_done), .i_frame_type(f_type), .i_frame_id(f_id),
      .i_short_frame(f_errs[3]), .i_err_mark(f_errs[2]), .i_fcs_fail(f_errs[1]),
      .i_frame_id_err(f_errs[0]), .i_blk_crc_err(f_blk), .i_node_count_in(f_nc),
      .i_block_count_in(f_bc), .i_node_sum(f_ns), .i_block_sum(f_bs),
      .i_mii_rx_er(rx_er), .i_mii_rx_dv(rx_dv), .o_receive_irq_n(irq_n),
      .o_sync_pulse_n(sync_n));

   task automatic end_sim();
      if (err_total == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // one avalon transfer, held until waitrequest is sampled low
   task automatic avs(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk);
         if (wait_req === 1'b0)
            break;
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n == 20)
      begin
         err_total++;
         end_sim();
      end
   endtask : avs

   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      avs(1'b0, a, '0);
      chk(nm, q, exp);
   endtask : rd_chk

   // frame with pulse check one cycle after the frame edge
   task automatic frame(input frame_type_t t, input logic [7:0] id, input logic [3:0] e,
      input logic [31:0] b, input logic [7:0] c, input logic [10:0] s, input logic p);
      src.send_frame(t, id, e, b, c, c, s, s);
      #1;
      chk("irq_n", {31'h0, irq_n}, {31'h0, !p});
      chk("sync_n", {31'h0, sync_n}, {31'h0, !p});
      @(posedge clk);
      #1;
      chk("irq_n_end", {31'h0, irq_n & sync_n}, 32'h1);
   endtask : frame

   task automatic s_reset();
      foreach (ra[i])
         rd_chk("reset", ra[i], (i == 0) ? 32'h8 : 32'h0);
      avs(1'b1, `RSS_OFF_NODE_POS, 32'hff);
      rd_chk("ro_write", `RSS_OFF_NODE_POS, 32'h0);
   endtask : s_reset

   task automatic s_config();
      frame(FT_INIT_A, 8'h55, 4'h0, '0, 8'h03, 11'h0, 1'b0);
      rd_chk("init_ignored", `RSS_OFF_STATE, 32'h8);
      avs(1'b1, `RSS_OFF_INIT_DONE, 32'h1);
      rd_chk("cfg_a", `RSS_OFF_STATE, 32'h4);
      frame(FT_INIT_A, 8'h11, 4'h0, '0, 8'h21, 11'h0, 1'b1);
      rd_chk("cfg_b", `RSS_OFF_STATE, 32'h1102);
      rd_chk("overflow", `RSS_OFF_OVERFLOW, 32'h3);
      rd_chk("position", `RSS_OFF_NODE_POS, 32'h21);
      rd_chk("first_blk", `RSS_OFF_FIRST_BLK, 32'h21);
      frame(FT_INIT_B, 8'h22, 4'h0, '0, 8'h0, 11'h20, 1'b1);
      rd_chk("run", `RSS_OFF_STATE, 32'h2201);
      rd_chk("node_tot", `RSS_OFF_NODE_TOT, 32'h20);
      rd_chk("blk_tot", `RSS_OFF_BLK_TOT, 32'h20);
   endtask : s_config

   task automatic s_errors();
      foreach (tbl[i])
      begin
         frame(tbl[i].t, 8'h30, tbl[i].e, '0, 8'h0, 11'h0, !(tbl[i].e[3] | tbl[i].e[0]));
         rd_chk("flags_prev", `RSS_OFF_ERR_FLAGS, 32'h0);
         frame(FT_REALTIME, 8'h31, 4'h0, '0, 8'h0, 11'h0, 1'b1);
         rd_chk("flags", `RSS_OFF_ERR_FLAGS, {16'h0, tbl[i].m});
         rd_chk("flags_clr", `RSS_OFF_ERR_FLAGS, 32'h0);
      end
   endtask : s_errors

   task automatic s_blocks();
      frame(FT_REALTIME, 8'h40, 4'h0, 32'h8001_0001, 8'h0, 11'h0, 1'b1);
      rd_chk("or_live", `RSS_OFF_ERR_FLAGS, 32'h40);
      rd_chk("or_kept", `RSS_OFF_ERR_FLAGS, 32'h40);
      rd_chk("blk_lo", `RSS_OFF_BLK_ERR_LO, 32'h0001);
      rd_chk("blk_hi", `RSS_OFF_BLK_ERR_HI, 32'h8001);
      rd_chk("blk_lo_clr", `RSS_OFF_BLK_ERR_LO, 32'h0);
      rd_chk("or_gone", `RSS_OFF_ERR_FLAGS, 32'h0);
      @(posedge clk);
      rx_er <= 1'b1;
      rx_dv <= 1'b1;
      repeat (3) @(posedge clk);
      rx_er <= 1'b0;
      rx_dv <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk("mii", `RSS_OFF_ERR_FLAGS, 32'h80);
   endtask : s_blocks

   task automatic s_tmo(input logic msk, input logic [7:0] s, input logic exp_irq);
      int ni;
      int nsy;
      ni = 0;
      nsy = 0;
      avs(1'b1, `RSS_OFF_IRQ_MASK, {31'h0, msk});
      avs(1'b1, `RSS_OFF_TIMEOUT, {24'h0, s});
      repeat (40)
      begin
         @(posedge clk);
         #1;
         ni += !irq_n;
         nsy += !sync_n;
      end
      avs(1'b1, `RSS_OFF_TIMEOUT, 32'h0);
      chk("tmo_irq", {31'h0, ni != 0}, {31'h0, exp_irq});
      chk("tmo_sync", nsy, 32'h0);
      rd_chk("tmo_flag", `RSS_OFF_ERR_FLAGS, (s != 0) ? 32'h2 : 32'h0);
   endtask : s_tmo

   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      s_reset();
      s_config();
      s_errors();
      s_blocks();
      s_tmo(1'b0, 8'h02, 1'b1);
      s_tmo(1'b1, 8'h02, 1'b0);
      s_tmo(1'b0, 8'h00, 1'b0);
      end_sim();
   end
endmodule : ring_slave_status_regs_tb_top
